// file: pwm_timer_capture_unit_test.sv
/*
 * self-checking bench of the pwm timer capture unit.
 * assumes pwmc_top, pwmc_src and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwm_timer_capture_unit_test
   import pwmc_pkg::*;
;
   typedef struct packed {logic [31:0] v; logic [31:0] m;} pwmc_exp_s;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        clk_en = 1'b1;
   logic        lp_clk = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [11:0] chan_in;
   logic [11:0] drv = 12'h0;
   logic [11:0] lvl = 12'h0;
   pwmc_exp_s   exp_q[$];
   int          fails = 0;
   int          total_checks = 0;
   int          seed = 40;

   always #5 ref_clk = ~ref_clk;

   pwmc_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .lp_clk(lp_clk),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_in(chan_in),
      .chan_out(), .chan_oe(), .chan_evt());
   pwmc_src src (.clk(ref_clk), .rst_b(rst_b), .drv(drv), .lvl(lvl), .pin(chan_in));

   // ----------------------------------------------------------------------
   // bus, tick and compare tasks
   // ----------------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input int ch, input logic [2:0] o, input logic [31:0] d);
      apb(1'b1, 12'(ch * 32) + {7'h0, o, 2'h0}, d);
   endtask

   task automatic rd(input int ch, input logic [2:0] o, input logic [31:0] v,
                     input logic [31:0] m = 32'hffffffff);
      exp_q.push_back('{v, m});
      apb(1'b0, 12'(ch * 32) + {7'h0, o, 2'h0}, 32'h0);
   endtask

   // lp_clk held still between pulses: counts stay exact
   task automatic tick(input int n);
      repeat (n)
      begin
         lp_clk <= 1'b1;
         @(posedge ref_clk);
         lp_clk <= 1'b0;
         repeat (3) @(posedge ref_clk);
      end
   endtask

   task automatic pin(input logic v);
      lvl[1] <= v;
      repeat (4) @(posedge ref_clk);
   endtask

   function automatic logic [31:0] cw(input logic en, input logic stp, input pwmc_mode_e md,
                                      input logic sl, input logic [1:0] eg, input logic [7:0] dv);
      return {8'h0, dv, 7'h0, 1'b0, eg, sl, 1'b1, md, stp, en};
   endfunction

   task automatic check_rd(input pwmc_exp_s e, input logic [31:0] got);
      total_checks++;
      if ((got & e.m) !== (e.v & e.m))
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got & e.m, e.v & e.m);
      end
   endtask

   always @(posedge ref_clk)
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
         check_rd(exp_q.pop_front(), prdata);

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   initial
   begin
      int ch;
      logic [31:0] r;
      logic [31:0] cap_exp [3] = '{32'h7, 32'h5, 32'h4};
      logic [5:0] wav_exp = 6'b011100;
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ch = $unsigned($random(seed)) % 12;
      rd(ch, `PWMC_OFF_CTRL, `PWMC_CTRL_RST);
      rd(ch, `PWMC_OFF_TOG3, `PWMC_TOG_RST);
      for (int o = 1; o <= 4; o++)
      begin
         r = $random(seed);
         wr(ch, 3'(o), r);
         rd(ch, 3'(o), r);
      end
      wr(12, `PWMC_OFF_PERIOD, 32'h5);
      rd(12, `PWMC_OFF_PERIOD, 32'h0);
      // timer on channel 0, period 4
      wr(0, `PWMC_OFF_PERIOD, 32'h4);
      wr(0, `PWMC_OFF_CTRL, cw(1'b1, 1'b0, PWMC_TIMER, 1'b0, 2'h0, 8'h0));
      tick(4);
      rd(0, `PWMC_OFF_COUNT, 32'h4);
      rd(0, `PWMC_OFF_STAT, 32'h0, 32'h1);
      tick(1);
      rd(0, `PWMC_OFF_COUNT, 32'h0);
      rd(0, `PWMC_OFF_STAT, 32'h1, 32'h1);
      wr(0, `PWMC_OFF_STAT, 32'h1);
      rd(0, `PWMC_OFF_STAT, 32'h0, 32'h1);
      tick(2);
      wr(0, `PWMC_OFF_CTRL, cw(1'b1, 1'b1, PWMC_TIMER, 1'b0, 2'h0, 8'h0));
      tick(2);
      rd(0, `PWMC_OFF_COUNT, 32'h2);
      wr(0, `PWMC_OFF_CTRL, cw(1'b1, 1'b0, PWMC_TIMER, 1'b0, 2'h0, 8'h0));
      tick(1);
      rd(0, `PWMC_OFF_COUNT, 32'h3);
      wr(0, `PWMC_OFF_PERIOD, 32'h2);
      rd(0, `PWMC_OFF_COUNT, 32'h0);
      tick(1);
      rd(0, `PWMC_OFF_COUNT, 32'h1);
      wr(0, `PWMC_OFF_CTRL, 32'h0);
      rd(0, `PWMC_OFF_COUNT, 32'h0);
      wr(0, `PWMC_OFF_PERIOD, 32'h64);
      wr(0, `PWMC_OFF_CTRL, cw(1'b1, 1'b0, PWMC_TIMER, 1'b0, 2'h0, 8'h2));
      tick(6);
      rd(0, `PWMC_OFF_COUNT, 32'h2);
      // waveform on channel 2: period 4, toggles at 1 and 3, start high
      wr(2, `PWMC_OFF_PERIOD, 32'h4);
      wr(2, `PWMC_OFF_TOG1, 32'h1);
      wr(2, `PWMC_OFF_TOG2, 32'h3);
      wr(2, `PWMC_OFF_TOG3, 32'h0);
      wr(2, `PWMC_OFF_CTRL, cw(1'b1, 1'b0, PWMC_WAVE, 1'b1, 2'h0, 8'h0));
      rd(2, `PWMC_OFF_STAT, 32'h2, 32'h3);
      for (int i = 0; i < 6; i++)
      begin
         tick(1);
         if (i == 1)
            wr(2, `PWMC_OFF_TOG1, 32'h2);
         rd(2, `PWMC_OFF_STAT, {30'h0, wav_exp[i], 1'b0}, 32'h3);
      end
      // capture on channel 1 over rise, fall and dual edge selections
      drv <= 12'h002;
      for (int e = 0; e < 3; e++)
      begin
         wr(1, `PWMC_OFF_CTRL, 32'h0);
         pin(1'b0);
         wr(1, `PWMC_OFF_CTRL, cw(1'b1, 1'b0, PWMC_CAPT, 1'b0, 2'(e), 8'h0));
         tick(2);
         pin(1'b1);
         tick(3);
         pin(1'b0);
         tick(4);
         pin(1'b1);
         rd(1, `PWMC_OFF_CAPT, cap_exp[e]);
         rd(1, `PWMC_OFF_STAT, 32'h1, 32'h1);
      end
      repeat (5) @(posedge ref_clk);
      close_out();
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      close_out();
   end
endmodule // pwm_timer_capture_unit_test

// file: pwmc_chk.sv
/*
 * port checker of the pwm timer capture unit, with its bind to pwmc_top.
 * assumes an apb master that holds each request until pready.
 */
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwmc_chk
   import pwmc_pkg::*;
(
   input logic        ref_clk,
   input logic        rst_b,
   input logic        clk_en,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic [11:0] chan_in,
   input logic [11:0] chan_out,
   input logic [11:0] chan_oe,
   input logic [11:0] chan_evt
);
   // ----------------------------------------------------------------------
   // control shadow, rebuilt from apb writes
   // ----------------------------------------------------------------------
   logic [31:0] ctrl_ff [12];
   logic [11:0] en_m;
   logic [11:0] wave_m;
   logic [11:0] rise_m;
   logic [11:0] fall_m;
   logic [3:0]  ch;
   logic        map_ok;
   logic        acc;

   assign ch     = paddr[8:5];
   assign map_ok = paddr[11:9] == 3'h0 && paddr[1:0] == 2'h0 && ch < 4'hc;
   assign acc    = psel && penable && pready && clk_en;

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < 12; i++)
            ctrl_ff[i] <= 32'h0;
      end
      else if (acc && pwrite && map_ok && paddr[4:2] == `PWMC_OFF_CTRL)
      begin
         ctrl_ff[ch] <= pwdata;
      end
   end

   // stop clear is part of the capture masks: a frozen channel is not checked
   always_comb
   begin
      for (int i = 0; i < 12; i++)
      begin
         en_m[i]   = ctrl_ff[i][`PWMC_CTRL_EN];
         wave_m[i] = en_m[i] && ctrl_ff[i][3:2] == PWMC_WAVE;
         rise_m[i] = en_m[i] && !ctrl_ff[i][1] && ctrl_ff[i][3:2] == PWMC_CAPT
                     && ctrl_ff[i][7:6] != PWMC_FALL && ctrl_ff[i][7:6] != PWMC_NONE;
         fall_m[i] = en_m[i] && !ctrl_ff[i][1] && ctrl_ff[i][3:2] == PWMC_CAPT
                     && ctrl_ff[i][7:6] != PWMC_RISE && ctrl_ff[i][7:6] != PWMC_NONE;
      end
   end

   // ----------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   ready_in_time_a: assert property (psel && !penable && clk_en |=> pready)
      else $error("pready missing in access cycle");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready held for two cycles");
   bad_addr_err_a: assert property (psel && !penable && clk_en && !map_ok |=> pslverr)
      else $error("unmapped address without error");
   good_addr_ok_a: assert property (psel && !penable && clk_en && map_ok |=> !pslverr)
      else $error("error on a mapped address");
   bad_read_zero_a: assert property (acc && !pwrite && !map_ok |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   wave_no_evt_a: assert property ((chan_evt & ~$past(chan_evt) & wave_m & $past(wave_m)) == 12'h0)
      else $error("event raised in waveform mode");
   oe_follow_a: assert property ($past(wave_m, 2) == wave_m && $past(wave_m) == wave_m |-> chan_oe == wave_m)
      else $error("output enable does not follow mode");
   idle_count_a: assert property (acc && !pwrite && map_ok && paddr[4:2] == `PWMC_OFF_COUNT
      && !en_m[ch] && !$past(en_m[ch]) |-> prdata == 32'h0)
      else $error("disabled channel count not zero");

   for (genvar i = 0; i < 12; i++)
   begin : g_ch
      cap_evt_a: assert property ((rise_m[i] && $rose(chan_in[i]) || fall_m[i] && $fell(chan_in[i]))
         && $past(rise_m[i] || fall_m[i]) && clk_en |-> ##[1:4] chan_evt[i])
         else $error("capture edge without event");
      off_no_evt_a: assert property ($rose(chan_evt[i]) |-> $past(en_m[i]) || $past(en_m[i], 2))
         else $error("event from a disabled channel");
   end

   cover property (acc && pwrite && map_ok && paddr[4:2] == `PWMC_OFF_CTRL);
   cover property ($rose(|chan_evt));
   cover property (|chan_oe && $changed(chan_out));
endmodule // pwmc_chk

bind pwmc_top pwmc_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .chan_in(chan_in), .chan_out(chan_out), .chan_oe(chan_oe), .chan_evt(chan_evt));

// file: pwmc_edge.sv
/*
 * capture edge qualifier of one channel.
 * assumes sig is synchronous to clk.
 */
`timescale 1ns/1ps
module pwmc_edge
   import pwmc_pkg::*;
(
   input  logic       clk,
   input  logic       rst_n,
   input  logic       clk_en,
   input  logic       sig,
   input  pwmc_edge_e edge_sel,
   output logic       hit
);

   logic prev_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_ff <= 1'b0;
      else if (clk_en)
         prev_ff <= sig;
   end

   always_comb
   begin
      case (edge_sel)
         PWMC_RISE: hit = sig & ~prev_ff;
         PWMC_FALL: hit = ~sig & prev_ff;
         PWMC_DUAL: hit = sig ^ prev_ff;
         default:   hit = 1'b0;
      endcase
   end

endmodule // pwmc_edge

// file: pwmc_map.svh
/*
 * register offsets, field positions and reset values of the pwm timer capture unit.
 * assumes inclusion by bare name from files that also import pwmc_pkg.
 */
`ifndef PWMC_MAP_SVH
`define PWMC_MAP_SVH

// ----------------------------------------------------------------------
// layout
// ----------------------------------------------------------------------
`define PWMC_NCH        12
`define PWMC_OFF_CTRL   3'h0
`define PWMC_OFF_PERIOD 3'h1
`define PWMC_OFF_TOG1   3'h2
`define PWMC_OFF_TOG2   3'h3
`define PWMC_OFF_TOG3   3'h4
`define PWMC_OFF_COUNT  3'h5
`define PWMC_OFF_CAPT   3'h6
`define PWMC_OFF_STAT   3'h7

// ----------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------
`define PWMC_CTRL_EN     0
`define PWMC_CTRL_STOP   1
`define PWMC_CTRL_MODE_L 2
`define PWMC_CTRL_MODE_H 3
`define PWMC_CTRL_LPSEL  4
`define PWMC_CTRL_LVL    5
`define PWMC_CTRL_EDGE_L 6
`define PWMC_CTRL_EDGE_H 7
`define PWMC_CTRL_PAIR   8
`define PWMC_CTRL_DIV_L  16
`define PWMC_CTRL_DIV_H  23
`define PWMC_STAT_EVT    0
`define PWMC_STAT_OUT    1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PWMC_CTRL_RST    32'h0000_0000
`define PWMC_PERIOD_RST  32'h0000_0000
`define PWMC_TOG_RST     32'h0000_0000

`endif

// file: pwmc_pkg.sv
/*
 * types shared by the pwm timer capture unit.
 * assumes nothing of its surroundings.
 */
package pwmc_pkg;

   // ----------------------------------------------------------------------
   // modes and capture edge selections
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      PWMC_TIMER = 2'b00,
      PWMC_WAVE  = 2'b01,
      PWMC_CAPT  = 2'b10,
      PWMC_IDLE  = 2'b11
   } pwmc_mode_e;

   typedef enum logic [1:0] {
      PWMC_RISE  = 2'b00,
      PWMC_FALL  = 2'b01,
      PWMC_DUAL  = 2'b10,
      PWMC_NONE  = 2'b11
   } pwmc_edge_e;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       en;
      logic       stop;
      pwmc_mode_e mode;
      logic       lp_sel;
      logic       lvl;
      pwmc_edge_e edge_sel;
      logic       pair;
      logic [7:0] div;
   } pwmc_ctrl_s;

   typedef struct packed {
      logic [31:0] period;
      logic [31:0] tog1;
      logic [31:0] tog2;
      logic [31:0] tog3;
      logic        lvl;
   } pwmc_wave_s;

endpackage

// file: pwmc_presc.sv
/*
 * counting tick of one channel: source clock choice and 1 to 256 prescaler.
 * assumes lp_clk is a slow level synchronous to clk, sampled as a plain input.
 */
`timescale 1ns/1ps
module pwmc_presc
   import pwmc_pkg::*;
(
   input  logic       clk,
   input  logic       rst_n,
   input  logic       clk_en,
   input  logic       run,
   input  logic       lp_sel,
   input  logic       lp_clk,
   input  logic [7:0] div,
   output logic       tick
);

   logic       lp_prev_ff;
   logic [7:0] div_cnt_ff;
   logic       tick_ff;
   logic       src;

   // low-power source advances once per rising edge of the slow clock
   assign src = lp_sel ? (lp_clk & ~lp_prev_ff) : 1'b1;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         lp_prev_ff <= 1'b0;
      else if (clk_en)
         lp_prev_ff <= lp_clk;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt_ff <= 8'h00;
         tick_ff    <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!run)
         begin
            div_cnt_ff <= 8'h00;
            tick_ff    <= 1'b0;
         end
         else if (src && div_cnt_ff == div)
         begin
            div_cnt_ff <= 8'h00;
            tick_ff    <= 1'b1;
         end
         else
         begin
            div_cnt_ff <= src ? div_cnt_ff + 8'h01 : div_cnt_ff;
            tick_ff    <= 1'b0;
         end
      end
   end

   assign tick = tick_ff;

endmodule // pwmc_presc

// file: pwmc_src.sv
/*
 * signal source standing on the channel input pins.
 * assumes drive and level commands change just after a clock edge.
 */
`timescale 1ns/1ps
module pwmc_src
(
   input  logic        clk,
   input  logic        rst_b,
   input  logic [11:0] drv,
   input  logic [11:0] lvl,
   output logic [11:0] pin
);
   logic [11:0] flip_ff;

   // an undriven pin flips every cycle so a stale level can never pass for data
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         flip_ff <= 12'h0;
      else
         flip_ff <= ~flip_ff;
   end

   assign pin = (drv & lvl) | (~drv & flip_ff);
endmodule // pwmc_src

// file: pwmc_top.sv
/*
 * twelve-channel 32-bit pwm, timer and capture unit with an apb register slave.
 * assumes apb signals and channel pins synchronous to ref_clk.
 */
// The implementer's own choices: the APB register port and the placing of the registers.
// Functional notes
// - twelve 32-bit channels: timer, waveform, capture
// - count clock: high-speed or low-power source
// - prescaler divides by 1 to 256
// - count up only, wrap to zero
// - per-channel enable and mode select
// - timer hits cycle value: event, restart
// - cycle value below count clears count
// - disable clears counter at once
// - stop freezes count, resume on release; a capture edge or pair restart still zeroes it
// - live count readable in timer mode
// - waveform starts at programmable level
// - waveform period one to two-pow-32 counts
// - three toggle times, zero disables one
// - paired neighbours start aligned, same period; the odd channel still wraps on its own period too
// - waveform mode raises no event
// - waveform settings apply at next restart
// - capture interval: rise, fall or dual
// - capture stores, raises event, overwrites
// - each channel own period and duty
`timescale 1ns/1ps
`include "pwmc_map.svh"
module pwmc_top
   import pwmc_pkg::*;
(
   input  logic        ref_clk,
   input  logic        rst_b,
   input  logic        clk_en,
   input  logic        lp_clk,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [11:0] paddr,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   input  logic [11:0] chan_in,
   output logic [11:0] chan_out,
   output logic [11:0] chan_oe,
   output logic [11:0] chan_evt
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic pwmc_ctrl_s ctrl_unpack(input logic [31:0] w);
      pwmc_ctrl_s c;
      c.en       = w[`PWMC_CTRL_EN];
      c.stop     = w[`PWMC_CTRL_STOP];
      c.mode     = pwmc_mode_e'(w[`PWMC_CTRL_MODE_H:`PWMC_CTRL_MODE_L]);
      c.lp_sel   = w[`PWMC_CTRL_LPSEL];
      c.lvl      = w[`PWMC_CTRL_LVL];
      c.edge_sel = pwmc_edge_e'(w[`PWMC_CTRL_EDGE_H:`PWMC_CTRL_EDGE_L]);
      c.pair     = w[`PWMC_CTRL_PAIR];
      c.div      = w[`PWMC_CTRL_DIV_H:`PWMC_CTRL_DIV_L];
      return c;
   endfunction

   function automatic logic [31:0] ctrl_pack(input pwmc_ctrl_s c);
      logic [31:0] w;
      w                                    = 32'h0000_0000;
      w[`PWMC_CTRL_EN]                     = c.en;
      w[`PWMC_CTRL_STOP]                   = c.stop;
      w[`PWMC_CTRL_MODE_H:`PWMC_CTRL_MODE_L] = c.mode;
      w[`PWMC_CTRL_LPSEL]                  = c.lp_sel;
      w[`PWMC_CTRL_LVL]                    = c.lvl;
      w[`PWMC_CTRL_EDGE_H:`PWMC_CTRL_EDGE_L] = c.edge_sel;
      w[`PWMC_CTRL_PAIR]                   = c.pair;
      w[`PWMC_CTRL_DIV_H:`PWMC_CTRL_DIV_L] = c.div;
      return w;
   endfunction

   // a zero toggle time never matches, so it switches that edge off
   function automatic logic tog_hit(input logic [31:0] val, input logic [31:0] t);
      return (t != 32'h0000_0000) && (val == t);
   endfunction

   // ----------------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic rst_n;

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   assign rst_n = rst_sync_ff;

   // ----------------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------------
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [3:0]  ch_sel;
   logic [2:0]  reg_off;
   logic        addr_bad;
   logic        setup;
   logic        wr_acc;
   logic [31:0] ch_rdata [`PWMC_NCH];
   logic [31:0] nxt_rdata;

   assign ch_sel   = paddr[8:5];
   assign reg_off  = paddr[4:2];
   assign addr_bad = (paddr[11:9] != 3'h0) || (paddr[1:0] != 2'h0) ||
                     (ch_sel >= 4'(`PWMC_NCH));
   assign setup    = psel & ~penable;
   // writes land on the access edge only, never in setup
   assign wr_acc   = psel & penable & pready_ff & pwrite & ~pslverr_ff;

   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (!addr_bad && !pwrite)
         nxt_rdata = ch_rdata[ch_sel];
   end

   // no wait state: pready rises in the first access cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         if (setup)
         begin
            pready_ff  <= 1'b1;
            pslverr_ff <= addr_bad;
            prdata_ff  <= nxt_rdata;
         end
         else
         begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
         end
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // ----------------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------------
   logic [`PWMC_NCH-1:0] restart_w;
   logic [`PWMC_NCH-1:0] pair_w;
   logic [`PWMC_NCH-1:0] out_w;
   logic [`PWMC_NCH-1:0] oe_w;
   logic [`PWMC_NCH-1:0] evt_w;

   for (genvar g = 0; g < `PWMC_NCH; g++)
   begin : gen_ch
      pwmc_ctrl_s  ctrl_ff;
      logic [31:0] period_ff;
      logic [31:0] tog1_ff;
      logic [31:0] tog2_ff;
      logic [31:0] tog3_ff;
      pwmc_wave_s  sh_ff;
      logic [31:0] cnt_ff;
      logic [31:0] capt_ff;
      logic        evt_ff;
      logic        out_ff;
      logic        oe_ff;
      logic        tick;
      logic        cap_hit;
      logic        sel_me;
      logic        is_tmr;
      logic        is_wave;
      logic        is_capt;
      logic        step;
      logic        wrap;
      logic        align;
      logic        restart;
      logic        evt_set;
      logic        stat_clr;
      logic [31:0] cnt_inc;

      assign sel_me  = wr_acc && (ch_sel == 4'(g));
      assign is_tmr  = ctrl_ff.en && (ctrl_ff.mode == PWMC_TIMER);
      assign is_wave = ctrl_ff.en && (ctrl_ff.mode == PWMC_WAVE);
      assign is_capt = ctrl_ff.en && (ctrl_ff.mode == PWMC_CAPT);
      assign step    = tick & ~ctrl_ff.stop;
      assign cnt_inc = cnt_ff + 32'h0000_0001;

      // in waveform mode a period of zero reads as two-pow-32: the count then wraps naturally
      always_comb
      begin
         case (ctrl_ff.mode)
            PWMC_TIMER: wrap = (cnt_ff == period_ff);
            PWMC_WAVE:  wrap = (cnt_inc == sh_ff.period);
            default:    wrap = 1'b0;
         endcase
      end

      // the odd channel of a pair restarts with its even neighbour
      if (g % 2 == 1)
      begin : gen_odd
         assign align = is_wave & pair_w[g-1] & restart_w[g-1];
      end
      else
      begin : gen_even
         assign align = 1'b0;
      end

      assign restart      = is_wave & ((step & wrap) | align);
      assign restart_w[g] = restart;
      assign pair_w[g]    = ctrl_ff.pair;

      pwmc_presc u_presc (
         .clk    (ref_clk),
         .rst_n  (rst_n),
         .clk_en (clk_en),
         .run    (ctrl_ff.en),
         .lp_sel (ctrl_ff.lp_sel),
         .lp_clk (lp_clk),
         .div    (ctrl_ff.div),
         .tick   (tick)
      );

      pwmc_edge u_edge (
         .clk      (ref_clk),
         .rst_n    (rst_n),
         .clk_en   (clk_en),
         .sig      (chan_in[g]),
         .edge_sel (ctrl_ff.edge_sel),
         .hit      (cap_hit)
      );

      // configuration registers
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            ctrl_ff   <= ctrl_unpack(`PWMC_CTRL_RST);
            period_ff <= `PWMC_PERIOD_RST;
            tog1_ff   <= `PWMC_TOG_RST;
            tog2_ff   <= `PWMC_TOG_RST;
            tog3_ff   <= `PWMC_TOG_RST;
         end
         else if (clk_en && sel_me)
         begin
            case (reg_off)
               `PWMC_OFF_CTRL:   ctrl_ff   <= ctrl_unpack(pwdata);
               `PWMC_OFF_PERIOD: period_ff <= pwdata;
               `PWMC_OFF_TOG1:   tog1_ff   <= pwdata;
               `PWMC_OFF_TOG2:   tog2_ff   <= pwdata;
               `PWMC_OFF_TOG3:   tog3_ff   <= pwdata;
               default:          ;
            endcase
         end
      end

      // waveform settings are held back until the counter restarts
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
         if (!rst_n)
            sh_ff <= '0;
         else if (clk_en && (!is_wave || restart))
            sh_ff <= '{period_ff, tog1_ff, tog2_ff, tog3_ff, ctrl_ff.lvl};
      end

      // counter
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
         if (!rst_n)
            cnt_ff <= 32'h0000_0000;
         else if (clk_en)
         begin
            if (!ctrl_ff.en)
               cnt_ff <= 32'h0000_0000;
            else if (is_tmr && cnt_ff > period_ff)
               cnt_ff <= 32'h0000_0000;
            else if (is_capt && cap_hit)
               cnt_ff <= 32'h0000_0000;
            else if (align)
               cnt_ff <= 32'h0000_0000;
            else if (step)
               cnt_ff <= wrap ? 32'h0000_0000 : cnt_inc;
         end
      end

      // capture result, overwritten whether read or not
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
         if (!rst_n)
            capt_ff <= 32'h0000_0000;
         else if (clk_en && is_capt && cap_hit)
            capt_ff <= cnt_ff;
      end

      // sticky event flag; a new event beats a clear in the same cycle
      assign evt_set  = (is_tmr & step & wrap) | (is_capt & cap_hit);
      assign stat_clr = sel_me && (reg_off == `PWMC_OFF_STAT) && pwdata[`PWMC_STAT_EVT];

      always_ff @(posedge ref_clk or negedge rst_n)
      begin
         if (!rst_n)
            evt_ff <= 1'b0;
         else if (clk_en)
            evt_ff <= evt_set | (evt_ff & ~stat_clr);
      end

      // waveform output
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
         if (!rst_n)
            out_ff <= 1'b0;
         else if (clk_en)
         begin
            if (!is_wave || !oe_ff || restart)
               out_ff <= ctrl_ff.lvl;
            else if (step)
               out_ff <= out_ff ^ tog_hit(cnt_inc, sh_ff.tog1) ^
                         tog_hit(cnt_inc, sh_ff.tog2) ^
                         tog_hit(cnt_inc, sh_ff.tog3);
         end
      end

      // the pin is driven only in waveform mode; capture leaves it an input
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
         if (!rst_n)
            oe_ff <= 1'b0;
         else if (clk_en)
            oe_ff <= is_wave;
      end

      // readback
      always_comb
      begin
         case (reg_off)
            `PWMC_OFF_CTRL:   ch_rdata[g] = ctrl_pack(ctrl_ff);
            `PWMC_OFF_PERIOD: ch_rdata[g] = period_ff;
            `PWMC_OFF_TOG1:   ch_rdata[g] = tog1_ff;
            `PWMC_OFF_TOG2:   ch_rdata[g] = tog2_ff;
            `PWMC_OFF_TOG3:   ch_rdata[g] = tog3_ff;
            `PWMC_OFF_COUNT:  ch_rdata[g] = cnt_ff;
            `PWMC_OFF_CAPT:   ch_rdata[g] = capt_ff;
            `PWMC_OFF_STAT:   ch_rdata[g] = {30'h0000_0000, out_ff, evt_ff};
            default:          ch_rdata[g] = 32'h0000_0000;
         endcase
      end

      assign out_w[g] = out_ff;
      assign oe_w[g]  = oe_ff;
      assign evt_w[g] = evt_ff;
   end

   assign chan_out = out_w;
   assign chan_oe  = oe_w;
   assign chan_evt = evt_w;

endmodule // pwmc_top
